// File: dco_defines.svh
`ifndef DCO_DEFINES_SVH
`define DCO_DEFINES_SVH

// register port geometry
`define DCO_ADDR_W      8
`define DCO_DATA_W      16

// register offsets
`define DCO_ADDR_LOWER  8'h00
`define DCO_ADDR_UPPER  8'h01
`define DCO_ADDR_RANGE  8'h02

// field positions
`define DCO_OE_BIT      10
`define DCO_UPPER_MSB   9
`define DCO_UPPER_W     10
`define DCO_LOWER_W     16
`define DCO_WORD_W      26
`define DCO_RANGE_MSB   3
`define DCO_RANGE_W     4
`define DCO_PPM_W       12

// reset values
`define DCO_LOWER_RST   16'h0000
`define DCO_UPPER_RST   10'h000
`define DCO_OE_RST      1'b0
`define DCO_RANGE_RST   4'h0
`define DCO_WORD_RST    26'h0000000
`define DCO_PPM_RST     12'h000
`define DCO_RDATA_RST   16'h0000

// pull range codes
`define DCO_CODE_25     4'h3
`define DCO_CODE_50     4'h4
`define DCO_CODE_80     4'h5
`define DCO_CODE_100    4'h6
`define DCO_CODE_125    4'h7
`define DCO_CODE_150    4'h8
`define DCO_CODE_200    4'h9
`define DCO_CODE_400    4'hA
`define DCO_CODE_600    4'hB
`define DCO_CODE_800    4'hC
`define DCO_CODE_1200   4'hD
`define DCO_CODE_1600   4'hE
`define DCO_CODE_3200   4'hF

// pull range magnitudes in ppm, symmetric about nominal
`define DCO_PPM_25      12'h019
`define DCO_PPM_50      12'h032
`define DCO_PPM_80      12'h050
`define DCO_PPM_100     12'h064
`define DCO_PPM_125     12'h07D
`define DCO_PPM_150     12'h096
`define DCO_PPM_200     12'h0C8
`define DCO_PPM_400     12'h190
`define DCO_PPM_600     12'h258
`define DCO_PPM_800     12'h320
`define DCO_PPM_1200    12'h4B0
`define DCO_PPM_1600    12'h640
`define DCO_PPM_3200    12'hC80

`endif

// File: dco_host_model.sv
`timescale 1ns/10ps
module dco_host_model
	import dco_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic [15:0] i_rdata,
	output reg_access_type   o_bus
);
	initial o_bus = '0;
	task automatic access(input logic w, input logic [7:0] a,
		input logic [15:0] d, output logic [15:0] q);
		@(posedge i_clk);
		o_bus <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge i_clk);
		// released lines invert so a stale value is never trusted
		o_bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		#1 q = i_rdata;
	endtask
	// junk in 15:11 on purpose, lower half goes first
	task automatic set_word(input logic [25:0] v, input logic oe);
		logic [15:0] q;
		access(1'b1, 8'h00, v[15:0], q);
		access(1'b1, 8'h01, {5'h1F, oe, v[25:16]}, q);
	endtask
endmodule

// File: dco_output_control_regs.sv
`timescale 1ns/10ps
`include "dco_defines.svh"

// Function
// - output/upper register bits 15:11 read zero
// - bit 10 is software output enable
// - hardware enable mode ignores software enable writes
// - bits 9:0 are pull word top
// - pull word resets to zero, nominal
// - pull word is signed two's complement
// - only upper word write applies pull
// - range register bits 15:4 read zero
// - bits 3:0 select range; 0-2 unused
// - range codes map to listed ppm spans
// - range loads factory value at power-up
module dco_output_control_regs
	import dco_pkg::*;
(
	input  wire logic                       i_clk,
	input  wire logic                       i_rst,
	input  wire reg_access_type             i_bus,
	input  wire logic                       i_oe_hw_mode,
	input  wire logic                       i_oe_pin,
	input  wire logic [`DCO_RANGE_W-1:0]    i_factory_range,
	output logic      [`DCO_DATA_W-1:0]     o_rdata,
	output logic                            o_rd_valid,
	output logic                            o_ready,
	output logic                            o_driver_en,
	output logic      [`DCO_WORD_W-1:0]     o_pending_word,
	output steering_type                    o_steer,
	output logic                            o_update
);

	// pin synchronisers
	logic                    mode_meta_ff;
	logic                    mode_sync_ff;
	logic                    pin_meta_ff;
	logic                    pin_sync_ff;
	logic [`DCO_RANGE_W-1:0] fact_meta_ff;
	logic [`DCO_RANGE_W-1:0] fact_sync_ff;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mode_meta_ff <= 1'b0;
			mode_sync_ff <= 1'b0;
			pin_meta_ff  <= 1'b0;
			pin_sync_ff  <= 1'b0;
			fact_meta_ff <= `DCO_RANGE_RST;
			fact_sync_ff <= `DCO_RANGE_RST;
		end else begin
			mode_meta_ff <= i_oe_hw_mode;
			mode_sync_ff <= mode_meta_ff;
			pin_meta_ff  <= i_oe_pin;
			pin_sync_ff  <= pin_meta_ff;
			fact_meta_ff <= i_factory_range;
			fact_sync_ff <= fact_meta_ff;
		end
	end

	// boot sequencer
	// the factory code needs two edges to cross the synchroniser,
	// so it is taken on the third edge; writes wait for run
	boot_state_type state_ff;
	boot_state_type nxt_state;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_FILL: begin
				nxt_state = ST_SETTLE;
			end
			ST_SETTLE: begin
				nxt_state = ST_LOAD;
			end
			ST_LOAD: begin
				nxt_state = ST_RUN;
			end
			ST_RUN: begin
				nxt_state = ST_RUN;
			end
			default: begin
				nxt_state = ST_FILL;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= ST_FILL;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// one decoder for every write strobe; nothing lands before run
	function automatic logic wr_hit(
		input reg_access_type         acc,
		input logic                   is_run,
		input logic [`DCO_ADDR_W-1:0] off
	);
		return is_run && acc.wr && (acc.addr == off);
	endfunction

	// pull word is always upper half over lower half
	function automatic logic [`DCO_WORD_W-1:0] join_word(
		input logic [`DCO_UPPER_W-1:0] hi,
		input logic [`DCO_LOWER_W-1:0] lo
	);
		return {hi, lo};
	endfunction

	// register file
	logic                    run;
	logic                    wr_lower;
	logic                    wr_upper;
	logic                    wr_range;
	logic [`DCO_LOWER_W-1:0] lower_ff;
	logic [`DCO_LOWER_W-1:0] nxt_lower;
	logic [`DCO_UPPER_W-1:0] upper_ff;
	logic [`DCO_UPPER_W-1:0] nxt_upper;
	logic                    oe_sw_ff;
	logic                    nxt_oe_sw;
	logic [`DCO_RANGE_W-1:0] range_ff;
	logic [`DCO_RANGE_W-1:0] nxt_range;

	always_comb begin
		run       = (state_ff == ST_RUN);
		wr_lower  = wr_hit(i_bus, run, `DCO_ADDR_LOWER);
		wr_upper  = wr_hit(i_bus, run, `DCO_ADDR_UPPER);
		wr_range  = wr_hit(i_bus, run, `DCO_ADDR_RANGE);
		nxt_lower = lower_ff;
		nxt_upper = upper_ff;
		nxt_oe_sw = oe_sw_ff;
		nxt_range = range_ff;
		if (wr_lower) begin
			// lower half is only held; it steers nothing yet
			nxt_lower = i_bus.wdata;
		end
		if (wr_upper) begin
			nxt_upper = i_bus.wdata[`DCO_UPPER_MSB:0];
			// bits 15:11 are simply never stored
			if (!mode_sync_ff) begin
				nxt_oe_sw = i_bus.wdata[`DCO_OE_BIT];
			end
		end
		if (state_ff == ST_LOAD) begin
			nxt_range = fact_sync_ff;
		end else if (wr_range) begin
			nxt_range = i_bus.wdata[`DCO_RANGE_MSB:0];
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			lower_ff <= `DCO_LOWER_RST;
			upper_ff <= `DCO_UPPER_RST;
			oe_sw_ff <= `DCO_OE_RST;
			range_ff <= `DCO_RANGE_RST;
		end else begin
			lower_ff <= nxt_lower;
			upper_ff <= nxt_upper;
			oe_sw_ff <= nxt_oe_sw;
			range_ff <= nxt_range;
		end
	end

	// range decode
	logic [`DCO_PPM_W-1:0] dec_ppm;
	logic                  dec_valid;

	pull_range_decode u_decode (
		.i_code  (range_ff),
		.o_ppm   (dec_ppm),
		.o_valid (dec_valid)
	);

	// steering latch
	// the word handed on takes its upper half from the write data directly, so
	// the strobe and the new word appear in the same cycle
	steering_type steer_ff;
	steering_type nxt_steer;
	logic         update_ff;
	logic         nxt_update;

	always_comb begin
		nxt_steer  = steer_ff;
		nxt_update = 1'b0;
		if (wr_upper) begin
			nxt_steer.word     = signed'(join_word(
				i_bus.wdata[`DCO_UPPER_MSB:0], lower_ff));
			nxt_steer.range    = range_ff;
			nxt_steer.ppm      = dec_ppm;
			nxt_steer.range_ok = dec_valid;
			nxt_update         = 1'b1;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			steer_ff.word     <= `DCO_WORD_RST;
			steer_ff.range    <= `DCO_RANGE_RST;
			steer_ff.ppm      <= `DCO_PPM_RST;
			steer_ff.range_ok <= 1'b0;
			update_ff         <= 1'b0;
		end else begin
			steer_ff  <= nxt_steer;
			update_ff <= nxt_update;
		end
	end

	// driver enable
	logic drv_ff;
	logic nxt_drv;

	always_comb begin
		// hardware mode hands the driver to the pin alone
		nxt_drv = mode_sync_ff ? pin_sync_ff : oe_sw_ff;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			drv_ff <= 1'b0;
		end else begin
			drv_ff <= nxt_drv;
		end
	end

	// read path
	// one cycle latency; unmapped offsets read as zero
	logic [`DCO_DATA_W-1:0] rdata_ff;
	logic [`DCO_DATA_W-1:0] nxt_rdata;
	logic                   rd_valid_ff;
	logic                   nxt_rd_valid;

	always_comb begin
		nxt_rdata    = `DCO_RDATA_RST;
		nxt_rd_valid = i_bus.rd;
		if (i_bus.rd) begin
			case (i_bus.addr)
				`DCO_ADDR_LOWER: begin
					nxt_rdata = lower_ff;
				end
				`DCO_ADDR_UPPER: begin
					nxt_rdata[`DCO_UPPER_MSB:0] = upper_ff;
					nxt_rdata[`DCO_OE_BIT]      = oe_sw_ff;
				end
				`DCO_ADDR_RANGE: begin
					nxt_rdata[`DCO_RANGE_MSB:0] = range_ff;
				end
				default: begin
					nxt_rdata = `DCO_RDATA_RST;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_ff    <= `DCO_RDATA_RST;
			rd_valid_ff <= 1'b0;
		end else begin
			rdata_ff    <= nxt_rdata;
			rd_valid_ff <= nxt_rd_valid;
		end
	end

	// ready flag
	logic ready_ff;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ready_ff <= 1'b0;
		end else begin
			ready_ff <= (nxt_state == ST_RUN);
		end
	end

	// staged word, for observation only
	logic [`DCO_WORD_W-1:0] pend_ff;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pend_ff <= `DCO_WORD_RST;
		end else begin
			pend_ff <= join_word(nxt_upper, nxt_lower);
		end
	end

	always_comb begin
		o_rdata        = rdata_ff;
		o_rd_valid     = rd_valid_ff;
		o_ready        = ready_ff;
		o_driver_en    = drv_ff;
		o_pending_word = pend_ff;
		o_steer        = steer_ff;
		o_update       = update_ff;
	end

endmodule

// File: dco_output_control_regs_test.sv
`timescale 1ns/10ps
module dco_output_control_regs_test
	import dco_pkg::*;
;
	logic           i_clk;
	logic           i_rst;
	logic           i_oe_hw_mode;
	logic           i_oe_pin;
	logic [3:0]     i_factory_range;
	reg_access_type bus;
	logic [15:0]    o_rdata;
	logic           o_rd_valid;
	logic           o_ready;
	logic           o_driver_en;
	logic [25:0]    o_pending_word;
	steering_type   o_steer;
	logic           o_update;
	logic [15:0]    q;
	logic [31:0]    r;
	logic           oe_m;
	int             err_total;
	int             cmp_count;
	int             rng_m;
	int             i;
	int             ppm_tab[16];
	logic [25:0]    word_q[$];

	dco_output_control_regs u_dco_output_control_regs (
		.i_clk(i_clk), .i_rst(i_rst), .i_bus(bus),
		.i_oe_hw_mode(i_oe_hw_mode), .i_oe_pin(i_oe_pin),
		.i_factory_range(i_factory_range), .o_rdata(o_rdata),
		.o_rd_valid(o_rd_valid), .o_ready(o_ready),
		.o_driver_en(o_driver_en), .o_pending_word(o_pending_word),
		.o_steer(o_steer), .o_update(o_update)
	);
	dco_host_model host (.i_clk(i_clk), .i_rdata(o_rdata), .o_bus(bus));

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s expected %0h seen %0h", n, e, s);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		host.access(1'b0, a, 16'h0000, d);
		chk("rdata", e, d);
		chk("rd_valid", 1, o_rd_valid);
	endtask
	task automatic chk_steer(input logic [25:0] v);
		int sw;
		sw = int'(v) - (v[25] ? 32'h0400_0000 : 0);
		chk("update", 1, o_update);
		chk("word", sw, $signed(o_steer.word));
		chk("range", rng_m, o_steer.range);
		chk("ppm", ppm_tab[rng_m], o_steer.ppm);
		chk("range_ok", rng_m > 2, o_steer.range_ok);
	endtask
	task automatic results;
		if (err_total == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	// run needs well under a thousand cycles
	initial begin
		#200us;
		err_total++;
		results();
	end
	initial begin
		void'($urandom(96129));
		ppm_tab = '{0, 0, 0, 25, 50, 80, 100, 125, 150, 200, 400, 600,
			800, 1200, 1600, 3200};
		i_rst = 1'b1;
		i_oe_hw_mode = 1'b0;
		i_oe_pin = 1'b0;
		rng_m = $urandom_range(15, 3);
		i_factory_range = rng_m[3:0];
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		for (i = 0; i < 20 && o_ready !== 1'b1; i++)
			@(posedge i_clk);
		#1 chk("word", 0, o_steer.word);
		chk("driver", 0, o_driver_en);
		rd(8'h01, 16'h0000);
		rd(8'h02, rng_m);
		rd(8'h07, 16'h0000);
		host.access(1'b1, 8'h00, 16'hBEEF, q);
		chk("update", 0, o_update);
		chk("pending", 26'h000BEEF, o_pending_word);
		chk("word", 0, o_steer.word);
		for (i = 0; i < 16; i++) begin
			r = $urandom;
			rng_m = i;
			oe_m = r[26];
			host.access(1'b1, 8'h02, {r[31:20], i[3:0]}, q);
			rd(8'h02, i);
			word_q.push_back(r[25:0]);
			host.set_word(r[25:0], oe_m);
			chk_steer(word_q.pop_front());
			chk("pending", r[25:0], o_pending_word);
			@(posedge i_clk);
			#1 chk("driver", oe_m, o_driver_en);
			rd(8'h01, {5'h00, oe_m, r[25:16]});
		end
		@(posedge i_clk);
		i_oe_hw_mode <= 1'b1;
		i_oe_pin <= 1'b1;
		repeat (8) @(posedge i_clk);
		#1 chk("driver", 1, o_driver_en);
		word_q.push_back(26'h0000000);
		host.set_word(26'h0000000, !oe_m);
		chk_steer(word_q.pop_front());
		chk("pending", 0, o_pending_word);
		rd(8'h01, {5'h00, oe_m, 10'h000});
		@(posedge i_clk);
		i_oe_pin <= 1'b0;
		repeat (8) @(posedge i_clk);
		#1 chk("driver", 0, o_driver_en);
		@(posedge i_clk);
		i_oe_hw_mode <= 1'b0;
		repeat (8) @(posedge i_clk);
		#1 chk("driver", oe_m, o_driver_en);
		results();
	end
endmodule

// File: dco_pkg.sv
`include "dco_defines.svh"

package dco_pkg;

	typedef struct packed {
		logic                       wr;
		logic                       rd;
		logic [`DCO_ADDR_W-1:0]     addr;
		logic [`DCO_DATA_W-1:0]     wdata;
	} reg_access_type;

	typedef struct packed {
		logic signed [`DCO_WORD_W-1:0] word;
		logic [`DCO_RANGE_W-1:0]       range;
		logic [`DCO_PPM_W-1:0]         ppm;
		logic                          range_ok;
	} steering_type;

	typedef enum logic [1:0] {
		ST_FILL   = 2'b00,
		ST_SETTLE = 2'b01,
		ST_LOAD   = 2'b10,
		ST_RUN    = 2'b11
	} boot_state_type;

endpackage

// File: dco_regs_properties.sv
`timescale 1ns/10ps
`include "dco_defines.svh"
module dco_regs_properties
	import dco_pkg::*;
(
	input wire logic                   i_clk,
	input wire logic                   i_rst,
	input wire reg_access_type         i_bus,
	input wire logic                   i_oe_hw_mode,
	input wire logic                   i_oe_pin,
	input wire logic [`DCO_DATA_W-1:0] o_rdata,
	input wire logic                   o_rd_valid,
	input wire logic                   o_ready,
	input wire logic                   o_driver_en,
	input wire logic [`DCO_WORD_W-1:0] o_pending_word,
	input wire steering_type           o_steer,
	input wire logic                   o_update
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence wr_up;
		i_bus.wr && i_bus.addr == `DCO_ADDR_UPPER && o_ready;
	endsequence
	// mode must settle through the synchroniser before the write counts
	sequence sw_wr_up;
		!i_oe_hw_mode [*3] ##0 wr_up;
	endsequence
	AST_HI_ZERO: assert property (i_bus.rd &&
		i_bus.addr == `DCO_ADDR_UPPER |=> o_rd_valid && o_rdata[15:11] == 5'h00)
		else $error("upper register high bits not zero");
	AST_RNG_ZERO: assert property (i_bus.rd &&
		i_bus.addr == `DCO_ADDR_RANGE |=> o_rd_valid && o_rdata[15:4] == 12'h000)
		else $error("range register high bits not zero");
	AST_APPLY: assert property (wr_up |=> o_update &&
		o_steer.word[25:16] == $past(i_bus.wdata[9:0]) &&
		o_steer.word[15:0] == $past(o_pending_word[15:0]))
		else $error("upper write did not apply word");
	AST_NO_UPD: assert property (!(i_bus.wr &&
		i_bus.addr == `DCO_ADDR_UPPER && o_ready) |=> !o_update)
		else $error("update without upper write");
	AST_HOLD: assert property (!o_update |-> $stable(o_steer))
		else $error("steering changed without update");
	AST_BOOT: assert property (!o_ready |-> o_steer.word == 26'h0000000 &&
		o_pending_word == 26'h0000000) else $error("word not zero at boot");
	AST_R150: assert property (o_update && o_steer.range == 4'h8
		|-> o_steer.ppm == 12'h096) else $error("code 8 not 150 ppm");
	AST_RNG_OK: assert property (o_update |->
		o_steer.range_ok == (o_steer.range > 4'h2)) else $error("range_ok wrong");
	AST_SW_OE: assert property (sw_wr_up |-> ##2
		o_driver_en == $past(i_bus.wdata[10], 2)) else $error("sw enable lost");
	AST_HW_OE: assert property ((i_oe_hw_mode && i_oe_pin) [*6]
		|-> o_driver_en) else $error("pin enable not followed");
endmodule

bind dco_output_control_regs dco_regs_properties u_props (
	.i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus),
	.i_oe_hw_mode(i_oe_hw_mode), .i_oe_pin(i_oe_pin),
	.o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .o_ready(o_ready),
	.o_driver_en(o_driver_en), .o_pending_word(o_pending_word),
	.o_steer(o_steer), .o_update(o_update)
);

// File: pull_range_decode.sv
`timescale 1ns/10ps
`include "dco_defines.svh"

module pull_range_decode (
	input  wire logic [`DCO_RANGE_W-1:0] i_code,
	output logic      [`DCO_PPM_W-1:0]   o_ppm,
	output logic                         o_valid
);

	function automatic logic [`DCO_PPM_W-1:0] code_to_ppm(
		input logic [`DCO_RANGE_W-1:0] code
	);
		logic [`DCO_PPM_W-1:0] ppm;
		ppm = `DCO_PPM_RST;
		case (code)
			`DCO_CODE_25:   ppm = `DCO_PPM_25;
			`DCO_CODE_50:   ppm = `DCO_PPM_50;
			`DCO_CODE_80:   ppm = `DCO_PPM_80;
			`DCO_CODE_100:  ppm = `DCO_PPM_100;
			`DCO_CODE_125:  ppm = `DCO_PPM_125;
			`DCO_CODE_150:  ppm = `DCO_PPM_150;
			`DCO_CODE_200:  ppm = `DCO_PPM_200;
			`DCO_CODE_400:  ppm = `DCO_PPM_400;
			`DCO_CODE_600:  ppm = `DCO_PPM_600;
			`DCO_CODE_800:  ppm = `DCO_PPM_800;
			`DCO_CODE_1200: ppm = `DCO_PPM_1200;
			`DCO_CODE_1600: ppm = `DCO_PPM_1600;
			`DCO_CODE_3200: ppm = `DCO_PPM_3200;
			// unused codes steer nothing
			default:        ppm = `DCO_PPM_RST;
		endcase
		return ppm;
	endfunction

	always_comb begin
		o_ppm   = code_to_ppm(i_code);
		o_valid = (code_to_ppm(i_code) != `DCO_PPM_RST);
	end

endmodule
